// *** design/rpa_pkg.sv ***
/*
 constants, types and helpers shared by the rotor position alignment files.
 assumes a 200 MHz aclk and an AXI4-Lite register window of 8 address bits.
*/
package rpa_pkg;
	localparam int unsigned CLK_KHZ = 200000;
	localparam int unsigned RAMP_TIME_MS = 1000;
	localparam int unsigned STEP_TIME_MS = 250;
	localparam int unsigned AXI_ADDR_W = 8;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_ORDER = 8'h0c;
	localparam logic [7:0] OFF_ENC_OFS = 8'h10;
	localparam logic [7:0] OFF_ALIGN_OFS = 8'h14;
	localparam logic [7:0] OFF_ENC_POS = 8'h18;

	localparam int unsigned CTRL_W = 7;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_METH_LSB = 1;
	localparam int unsigned CTRL_PWRON_BIT = 3;
	localparam int unsigned CTRL_INV_BIT = 4;
	localparam int unsigned CTRL_PH_LSB = 5;
	localparam int unsigned CMD_START_BIT = 0;
	localparam int unsigned CMD_STOP_BIT = 1;
	localparam int unsigned CMD_TOFF_BIT = 2;
	localparam int unsigned ST_CODE_LSB = 0;
	localparam int unsigned ST_ENDED_BIT = 4;
	localparam int unsigned ST_ERR_LSB = 8;
	localparam int unsigned ST_TRIP_BIT = 12;
	localparam int unsigned ST_DIR_BIT = 16;
	localparam int unsigned ST_SPD_OK_BIT = 17;

	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	localparam logic ORDER_RST = 1'b0;
	localparam logic [15:0] ENC_OFS_RST = 16'h0000;
	localparam logic [15:0] MIN_MOVE = 16'h0100;
	localparam logic [7:0] TRIP_CODE = 8'h2e;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// electrical angle, full turn is 2^16: 90, 210 and 330 degrees
	localparam logic [15:0] ANG_U = 16'h4000;
	localparam logic [15:0] ANG_V = 16'h9555;
	localparam logic [15:0] ANG_W = 16'heaab;

	typedef enum logic [1:0] {METH_MANUAL = 2'h0, METH_AUTO = 2'h1, METH_DIRTEST = 2'h2}
		rpa_method_type;
	typedef enum logic [1:0] {PH_U = 2'h0, PH_V = 2'h1, PH_W = 2'h2} rpa_phase_type;
	typedef enum logic [2:0] {ACODE_OFF = 3'h0, ACODE_ON_MANUAL = 3'h1, ACODE_ON_AUTO = 3'h2,
		ACODE_ERROR = 3'h3, ACODE_ENDED = 3'h4} rpa_acode_type;
	typedef enum logic [2:0] {ERR_NONE = 3'h0, ERR_SHAFT_LOCKED = 3'h1, ERR_AMPS = 3'h2,
		ERR_LOAD = 3'h3, ERR_POLES = 3'h4, ERR_UNCONNECTED = 3'h5, ERR_ENCODER = 3'h6,
		ERR_INIT_NEEDED = 3'h7} rpa_err_type;
	typedef enum logic [2:0] {S_OFF = 3'b000, S_HOLD = 3'b001, S_MOVE = 3'b011,
		S_FINAL = 3'b010, S_DONE = 3'b110, S_DIRT = 3'b101, S_ERR = 3'b100} rpa_state_type;

	function automatic rpa_phase_type rpa_swap_vw(input rpa_phase_type p, input logic rev);
		rpa_phase_type r;
		r = p;
		if (rev && p == PH_V) begin
			r = PH_W;
		end else if (rev && p == PH_W) begin
			r = PH_V;
		end
		return r;
	endfunction

	function automatic logic rpa_active(input rpa_state_type s);
		return (s == S_HOLD) || (s == S_MOVE) || (s == S_FINAL) || (s == S_DIRT);
	endfunction

	function automatic logic rpa_reg_hit(input logic [7:0] a);
		return (a == OFF_CTRL) || (a == OFF_CMD) || (a == OFF_STATUS) || (a == OFF_ORDER) ||
			(a == OFF_ENC_OFS) || (a == OFF_ALIGN_OFS) || (a == OFF_ENC_POS);
	endfunction
endpackage

// *** design/rpa_phase_map.sv ***
/*
 maps an electrical phase index to the physical phase that is energised
 and to the electrical angle at which that phase holds the rotor.
 assumes the caller registers the outputs.
*/
`timescale 1ns/10ps
module rpa_phase_map (
	input wire rpa_pkg::rpa_phase_type elec,
	input wire logic reverse,
	output logic [2:0] drive,
	output logic [15:0] angle
);
	import rpa_pkg::*;

	rpa_phase_type phys;

	// reverse order drives V and W swapped, so U,V,W steps come out U,W,V
	assign phys = rpa_swap_vw(elec, reverse);
	assign drive = (phys == PH_U) ? 3'b001 : (phys == PH_V) ? 3'b010 : 3'b100;
	assign angle = (phys == PH_U) ? ANG_U : (phys == PH_V) ? ANG_V : ANG_W;
endmodule

// *** design/rpa_align.sv ***
/*
 rotor position alignment sequencer with its AXI4-Lite register slave.
 assumes enc_pos, fault_valid and fault_code come from logic on aclk, and
 that a current loop outside turns phase_drive into the alignment current.
*/
`timescale 1ns/10ps
module rpa_align #(
	parameter int unsigned RAMP_CYCLES = rpa_pkg::RAMP_TIME_MS * rpa_pkg::CLK_KHZ,
	parameter int unsigned STEP_CYCLES = rpa_pkg::STEP_TIME_MS * rpa_pkg::CLK_KHZ
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [rpa_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [rpa_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [15:0] enc_pos,
	input wire logic fault_valid,
	input wire rpa_pkg::rpa_err_type fault_code,
	output logic [2:0] phase_drive,
	output rpa_pkg::rpa_acode_type align_state,
	output logic align_ended,
	output rpa_pkg::rpa_err_type align_error,
	output logic alignment_trip,
	output logic [7:0] trip_code,
	output logic speed_ctrl_valid,
	output logic motor_phase_order,
	output logic [15:0] encoder_zero_offset
);
	import rpa_pkg::*;

	localparam logic [31:0] RAMP_LAST = 32'(RAMP_CYCLES - 1);
	localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 1);

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q, wdata_q;
	logic [7:0] awaddr_q;
	logic [3:0] wstrb_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic start_q, stop_q, toff_q;
	rpa_state_type state_q, state_d;
	rpa_phase_type elec_q, elec_d;
	logic [31:0] tmr_q;
	logic order_q, dir_q, aligned_q, trip_q, ended_q, spd_ok_q;
	rpa_err_type err_q;
	rpa_acode_type acode_q;
	logic [15:0] encofs_q, alignofs_q, pos0_q;
	logic [2:0] phase_drive_q;
	logic [7:0] trip_code_q;

	wire en = ctrl_q[CTRL_EN_BIT];
	wire pwron = ctrl_q[CTRL_PWRON_BIT];
	wire inv = ctrl_q[CTRL_INV_BIT];
	wire rpa_method_type method = rpa_method_type'(ctrl_q[CTRL_METH_LSB +: 2]);
	wire [1:0] msel_raw = ctrl_q[CTRL_PH_LSB +: 2];
	wire rpa_phase_type msel = (msel_raw == 2'h3) ? PH_U : rpa_phase_type'(msel_raw);

	wire active = rpa_active(state_q);
	wire go = start_q && en && !active;
	// torque_removal_command is the controller's normal way out of a running sequence
	wire abort = (stop_q || toff_q || !en) && active;
	wire init_trip = start_q && !en && pwron && !aligned_q;
	wire fault = fault_valid && active;
	wire timeout = (state_q == S_DIRT) ? (tmr_q == STEP_LAST) : (tmr_q == RAMP_LAST);
	wire [15:0] delta = enc_pos - pos0_q;
	wire [15:0] dmag = delta[15] ? 16'(-delta) : delta;
	wire locked = dmag < MIN_MOVE;
	wire [2:0] drive_w;
	wire [15:0] theo_ang;
	wire [15:0] new_ofs = enc_pos - theo_ang;

	// the drive map follows the order in use, the angle map whether that order is flipped on write-back
	rpa_phase_map u_drive_map (
		.elec(elec_d),
		.reverse(order_q),
		.drive(drive_w),
		.angle()
	);
	rpa_phase_map u_theo_map (
		.elec(elec_q),
		.reverse(dir_q ^ order_q),
		.drive(),
		.angle(theo_ang)
	);

	always_comb begin
		state_d = state_q;
		elec_d = elec_q;
		if (init_trip) begin
			state_d = S_ERR;
		end else if (go) begin
			state_d = (method == METH_DIRTEST) ? S_DIRT : S_HOLD;
			// manual picks the electrical slot of the chosen physical phase
			elec_d = (method == METH_MANUAL) ? rpa_swap_vw(msel, order_q) : PH_U;
		end else if (abort) begin
			state_d = S_OFF;
		end else if (fault) begin
			state_d = S_ERR;
		end else begin
			case (state_q)
				S_HOLD: begin
					if (timeout && method == METH_AUTO) begin
						state_d = S_MOVE;
						elec_d = PH_V;
					end else if (timeout) begin
						state_d = S_FINAL;
					end
				end
				S_MOVE: begin
					if (timeout) begin
						state_d = locked ? S_ERR : S_FINAL;
					end
				end
				S_FINAL: begin
					state_d = S_DONE;
				end
				S_DIRT: begin
					// stepping is electrical; the map makes reverse order turn backwards
					if (timeout) begin
						elec_d = (elec_q == PH_W) ? PH_U : rpa_phase_type'(elec_q + 2'h1);
					end
				end
				default: begin
				end
			endcase
		end
	end

	wire tmr_clr = (state_d != state_q) || (elec_d != elec_q) || go;
	wire err_entry = (state_d == S_ERR) && (state_q != S_ERR);
	wire rpa_err_type err_new = init_trip ? ERR_INIT_NEEDED : fault ? fault_code : ERR_SHAFT_LOCKED;
	wire rpa_acode_type acode_w = (state_q == S_ERR) ? ACODE_ERROR :
		(state_q == S_DONE) ? ACODE_ENDED :
		!en ? ACODE_OFF :
		(method == METH_AUTO) ? ACODE_ON_AUTO : ACODE_ON_MANUAL;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= S_OFF;
			elec_q <= PH_U;
			tmr_q <= 32'h0;
			pos0_q <= 16'h0;
			dir_q <= ORDER_RST;
			err_q <= ERR_NONE;
			trip_q <= 1'b0;
			aligned_q <= 1'b0;
		end else begin
			state_q <= state_d;
			elec_q <= elec_d;
			tmr_q <= tmr_clr ? 32'h0 : tmr_q + 32'h1;
			if (state_q == S_HOLD && timeout) begin
				pos0_q <= enc_pos;
			end
			if (go) begin
				dir_q <= order_q;
			end else if (state_q == S_MOVE && timeout && !locked) begin
				dir_q <= order_q ^ delta[15];
			end
			// an early start while already in error must still record init-needed
			if (err_entry || init_trip) begin
				err_q <= err_new;
			end else if (go) begin
				err_q <= ERR_NONE;
			end
			if (init_trip) begin
				trip_q <= 1'b1;
			end else if (go) begin
				trip_q <= 1'b0;
			end
			if (state_d == S_DONE) begin
				aligned_q <= 1'b1;
			end
		end
	end

	// status outputs are registered so every output leaves a flip-flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_drive_q <= 3'h0;
			acode_q <= ACODE_OFF;
			ended_q <= 1'b0;
			spd_ok_q <= 1'b0;
			trip_code_q <= 8'h00;
		end else begin
			phase_drive_q <= rpa_active(state_d) ? drive_w : 3'h0;
			acode_q <= acode_w;
			ended_q <= (state_q == S_DONE);
			spd_ok_q <= (order_q == inv);
			trip_code_q <= trip_q ? TRIP_CODE : 8'h00;
		end
	end

	wire wr_fire = !awready_q && !wready_q && !bvalid_q;
	wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire [31:0] wmerge_ctrl = (32'(ctrl_q) & ~wmask) | (wdata_q & wmask);
	wire wr_cmd = wr_fire && awaddr_q == OFF_CMD && wstrb_q[0];
	wire wr_order = wr_fire && awaddr_q == OFF_ORDER && wstrb_q[0];
	wire [31:0] wmerge_ofs = (32'(encofs_q) & ~wmask) | (wdata_q & wmask);
	wire [31:0] status_w = (32'(acode_q) << ST_CODE_LSB) | (32'(ended_q) << ST_ENDED_BIT) |
		(32'(err_q) << ST_ERR_LSB) | (32'(trip_q) << ST_TRIP_BIT) |
		(32'(dir_q) << ST_DIR_BIT) | (32'(spd_ok_q) << ST_SPD_OK_BIT);
	wire [7:0] ra = araddr;
	wire [31:0] rd_word = (ra == OFF_CTRL) ? 32'(ctrl_q) :
		(ra == OFF_STATUS) ? status_w :
		(ra == OFF_ORDER) ? 32'(order_q) :
		(ra == OFF_ENC_OFS) ? 32'(encofs_q) :
		(ra == OFF_ALIGN_OFS) ? 32'(alignofs_q) :
		(ra == OFF_ENC_POS) ? 32'(enc_pos) : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			ctrl_q <= CTRL_RST;
			start_q <= 1'b0;
			stop_q <= 1'b0;
			toff_q <= 1'b0;
		end else begin
			if (awvalid && awready_q) begin
				awaddr_q <= awaddr;
				awready_q <= 1'b0;
			end
			if (wvalid && wready_q) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
				wready_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= rpa_reg_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
			if (wr_fire && awaddr_q == OFF_CTRL) begin
				ctrl_q <= wmerge_ctrl[CTRL_W-1:0];
			end
			start_q <= wr_cmd && wdata_q[CMD_START_BIT];
			stop_q <= wr_cmd && wdata_q[CMD_STOP_BIT];
			toff_q <= wr_cmd && wdata_q[CMD_TOFF_BIT];
		end
	end

	// the sequencer's write-back wins over a software write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			order_q <= ORDER_RST;
			encofs_q <= ENC_OFS_RST;
			alignofs_q <= ENC_OFS_RST;
		end else if (state_q == S_FINAL) begin
			order_q <= dir_q;
			encofs_q <= new_ofs;
			alignofs_q <= new_ofs;
		end else begin
			if (wr_order) begin
				order_q <= wdata_q[0];
			end
			if (wr_fire && awaddr_q == OFF_ENC_OFS) begin
				encofs_q <= wmerge_ofs[15:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rpa_reg_hit(ra) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign phase_drive = phase_drive_q;
	assign align_state = acode_q;
	assign align_ended = ended_q;
	assign align_error = err_q;
	assign alignment_trip = trip_q;
	assign trip_code = trip_code_q;
	assign speed_ctrl_valid = spd_ok_q;
	assign motor_phase_order = order_q;
	assign encoder_zero_offset = encofs_q;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_go;
		start_q && en && !active;
	endsequence
	sequence s_cleared;
		err_q == ERR_NONE && !trip_q;
	endsequence

	property p_swap_vw;
		(state_q == S_DIRT && order_q && $stable(order_q) && elec_q == PH_V) |->
			phase_drive_q == 3'b100;
	endproperty
	a_swap_vw: assert property (p_swap_vw) else $error("reverse order did not swap V and W");
	property p_order_copy;
		(state_q == S_FINAL && !abort && !fault && !init_trip) |=>
			order_q == $past(dir_q) && state_q == S_DONE;
	endproperty
	a_order_copy: assert property (p_order_copy) else $error("order not written back");
	property p_ended_code;
		state_q == S_DONE |=> acode_q == ACODE_ENDED && ended_q;
	endproperty
	a_ended_code: assert property (p_ended_code) else $error("ended not reported");
	property p_auto_code;
		(state_q != S_ERR && state_q != S_DONE && en && method == METH_AUTO) |=>
			acode_q == ACODE_ON_AUTO;
	endproperty
	a_auto_code: assert property (p_auto_code) else $error("auto state code wrong");
	property p_no_ended_run;
		rpa_active(state_q) |=> !ended_q;
	endproperty
	a_no_ended_run: assert property (p_no_ended_run) else $error("ended while running");
	property p_err_clear;
		s_go |=> s_cleared;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("start kept an old error");
	property p_init_trip;
		init_trip |=> trip_q && err_q == ERR_INIT_NEEDED ##1 trip_code_q == TRIP_CODE;
	endproperty
	a_init_trip: assert property (p_init_trip) else $error("missing alignment did not trip");
	property p_wait_start;
		(state_q == S_OFF && !start_q) |=> state_q == S_OFF;
	endproperty
	a_wait_start: assert property (p_wait_start) else $error("left idle without start");
	property p_stop;
		(active && (stop_q || toff_q) && !init_trip) |=> state_q == S_OFF && phase_drive_q == 3'h0;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not end sequence");
	property p_dirt_onehot;
		state_q == S_DIRT |-> $onehot(phase_drive_q);
	endproperty
	a_dirt_onehot: assert property (p_dirt_onehot) else $error("direction test drive not one-hot");
	property p_err_hold;
		(state_q == S_ERR && !start_q) |=> state_q == S_ERR && err_q == $past(err_q);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error not held");
endmodule

// *** verification/rpa_motor_model.sv ***
/*
 motor and relative encoder model facing the alignment sequencer.
 assumes phase_drive is one-hot {W,V,U} on aclk; the bench sets the encoder
 mounting offset, the encoder counting direction and a locked shaft.
*/
`timescale 1ns/10ps
module rpa_motor_model (
	input wire logic aclk,
	input wire logic [2:0] phase_drive,
	input wire logic [15:0] mech_ofs,
	input wire logic enc_neg,
	input wire logic locked,
	output logic [15:0] enc_pos
);
	import rpa_pkg::*;
	logic [15:0] rotor_q = 16'h0000;
	logic [15:0] rotor_d;
	// rotor settles at once on the energised phase; unpowered it stays put
	assign rotor_d = locked ? rotor_q : phase_drive[0] ? ANG_U : phase_drive[1] ? ANG_V :
		phase_drive[2] ? ANG_W : rotor_q;
	always @(posedge aclk) begin
		rotor_q <= rotor_d;
	end
	// an encoder mounted the other way round counts down as the rotor turns forward
	assign enc_pos = enc_neg ? mech_ofs - rotor_q : rotor_q + mech_ofs;
endmodule

// *** verification/rpa_align_tb_top.sv ***
/*
 self-checking bench for the alignment sequencer, driven over AXI4-Lite.
 assumes the motor model file is compiled first; RAMP 20 and STEP 8 cycles.
*/
`timescale 1ns/10ps
module rpa_align_tb_top;
	import rpa_pkg::*;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rpa_note_type;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, v;
	logic [3:0] wstrb = 4'hf;
	logic fault_valid = 1'b0, enc_neg = 1'b0, locked = 1'b0;
	rpa_err_type fault_code = ERR_NONE;
	logic [15:0] mech_ofs = 16'h0000, enc_pos, encoder_zero_offset;
	logic awready, wready, bvalid, arready, rvalid, align_ended, alignment_trip;
	logic speed_ctrl_valid, motor_phase_order;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] phase_drive, prev;
	logic [7:0] trip_code;
	rpa_acode_type align_state;
	rpa_err_type align_error;
	rpa_note_type notes[$];
	rpa_note_type note;
	int errors = 0, checks = 0, n, p, c, k, seed;

	always #2.5 aclk = ~aclk;

	rpa_align #(.RAMP_CYCLES(20), .STEP_CYCLES(8)) dut (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .enc_pos(enc_pos), .fault_valid(fault_valid),
		.fault_code(fault_code), .phase_drive(phase_drive), .align_state(align_state),
		.align_ended(align_ended), .align_error(align_error),
		.alignment_trip(alignment_trip), .trip_code(trip_code),
		.speed_ctrl_valid(speed_ctrl_valid), .motor_phase_order(motor_phase_order),
		.encoder_zero_offset(encoder_zero_offset));

	rpa_motor_model motor (.aclk(aclk), .phase_drive(phase_drive), .mech_ofs(mech_ofs),
		.enc_neg(enc_neg), .locked(locked), .enc_pos(enc_pos));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic bounded(input logic ok);
		if (!ok) begin
			check(32'h0, 32'h1);
			print_verdict();
		end
	endtask

	// responses are judged by the monitor below, in the order they were asked for
	always @(posedge aclk) begin
		if ((bvalid && bready) || (rvalid && rready)) begin
			if (notes.size() == 0) begin
				check(32'h1, 32'h0);
			end else begin
				note = notes.pop_front();
				check(32'(bvalid ? bresp : rresp), 32'(note.r));
				if (rvalid) check(rdata & note.m, note.d);
			end
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		notes.push_back('{32'h0, 32'h0, r});
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		bounded(i < 100);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] r);
		int i;
		notes.push_back('{d, m, r});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		bounded(i < 100);
	endtask

	task automatic wait_state(input rpa_acode_type s);
		int i;
		for (i = 0; i < 400 && align_state !== s; i++) @(posedge aclk);
		bounded(align_state === s);
	endtask

	task automatic next_drive(input logic [2:0] old);
		int i;
		for (i = 0; i < 400 && phase_drive === old; i++) @(posedge aclk);
		bounded(phase_drive !== old);
	endtask

	function automatic logic [31:0] ctrl(input logic en, input logic [1:0] m, input logic pw,
		input logic inv, input logic [1:0] ph);
		return {25'h0, ph, inv, pw, m, en};
	endfunction

	// electrical phase e held with the V and W wires swapped when rev is set
	function automatic logic [31:0] exp_drive(input int e, input logic rev);
		int s;
		s = (rev && e != 0) ? 3 - e : e;
		return 32'(1 << s);
	endfunction

	initial begin
		seed = $urandom(5);
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_CTRL, 32'h0, 32'hffffffff, RESP_OKAY);
		rd(OFF_ORDER, 32'h0, 32'hffffffff, RESP_OKAY);
		rd(8'h1c, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr(8'h1c, 32'h1, RESP_SLVERR);
		v = $urandom();
		wr(OFF_ENC_OFS, v, RESP_OKAY);
		rd(OFF_ENC_OFS, {16'h0, v[15:0]}, 32'hffff, RESP_OKAY);
		$display("register test done");
		// first start since reset with power-on alignment demanded
		wr(OFF_CTRL, ctrl(1'b0, METH_MANUAL, 1'b1, 1'b0, 2'h0), RESP_OKAY);
		wr(OFF_CMD, 32'h1, RESP_OKAY);
		for (n = 0; n < 50 && alignment_trip !== 1'b1; n++) @(posedge aclk);
		bounded(alignment_trip === 1'b1);
		@(posedge aclk);
		check(32'(trip_code), 32'(TRIP_CODE));
		check(32'(align_error), 32'(ERR_INIT_NEEDED));
		rd(OFF_STATUS, 32'h1700, 32'h1700, RESP_OKAY);
		$display("power-on trip test done");
		for (p = 0; p < 3; p++) begin
			mech_ofs <= 16'($urandom());
			wr(OFF_CTRL, ctrl(1'b1, METH_MANUAL, 1'b0, 1'b0, 2'(p)), RESP_OKAY);
			repeat (10) @(posedge aclk);
			check(32'(phase_drive), 32'h0);
			wr(OFF_CMD, 32'h1, RESP_OKAY);
			wait_state(ACODE_ON_MANUAL);
			check(32'(align_ended), 32'h0);
			check(32'(align_error), 32'(ERR_NONE));
			next_drive(3'h0);
			check(32'(phase_drive), exp_drive(p, 1'b0));
			wait_state(ACODE_ENDED);
			repeat (2) @(posedge aclk);
			check(32'(align_ended), 32'h1);
			rd(OFF_ENC_OFS, {16'h0, mech_ofs}, 32'hffff, RESP_OKAY);
			rd(OFF_STATUS, 32'h0014, 32'h0717, RESP_OKAY);
		end
		$display("manual test done");
		// manual energises the selected wire in either order; only its electrical slot moves
		wr(OFF_ORDER, 32'h1, RESP_OKAY);
		wr(OFF_CTRL, ctrl(1'b1, METH_MANUAL, 1'b0, 1'b0, 2'h1), RESP_OKAY);
		wr(OFF_CMD, 32'h1, RESP_OKAY);
		wait_state(ACODE_ON_MANUAL);
		next_drive(3'h0);
		check(32'(phase_drive), exp_drive(1, 1'b0));
		wr(OFF_CMD, 32'h2, RESP_OKAY);
		next_drive(3'b010);
		repeat (2) @(posedge aclk);
		check(32'(phase_drive), 32'h0);
		// still enabled for manual, so the code reads manual rather than off
		check(32'(align_state), 32'(ACODE_ON_MANUAL));
		wr(OFF_ORDER, 32'h0, RESP_OKAY);
		for (c = 1; c < 7; c++) begin
			wr(OFF_CMD, 32'h1, RESP_OKAY);
			wait_state(ACODE_ON_MANUAL);
			next_drive(3'h0);
			check(32'(align_error), 32'(ERR_NONE));
			fault_code <= rpa_err_type'(c);
			fault_valid <= 1'b1;
			@(posedge aclk);
			fault_valid <= 1'b0;
			wait_state(ACODE_ERROR);
			repeat (30) @(posedge aclk);
			check(32'(align_state), 32'(ACODE_ERROR));
			check(32'(align_error), c);
		end
		$display("stop and fault test done");
		mech_ofs <= 16'($urandom());
		wr(OFF_CTRL, ctrl(1'b1, METH_AUTO, 1'b0, 1'b0, 2'h0), RESP_OKAY);
		wr(OFF_CMD, 32'h1, RESP_OKAY);
		wait_state(ACODE_ON_AUTO);
		wait_state(ACODE_ENDED);
		repeat (2) @(posedge aclk);
		check(32'(motor_phase_order), 32'h0);
		check(32'(encoder_zero_offset), 32'(mech_ofs));
		check(32'(speed_ctrl_valid), 32'h1);
		rd(OFF_ALIGN_OFS, {16'h0, mech_ofs}, 32'hffff, RESP_OKAY);
		enc_neg <= 1'b1;
		wr(OFF_CTRL, ctrl(1'b1, METH_AUTO, 1'b0, 1'b1, 2'h0), RESP_OKAY);
		wr(OFF_CMD, 32'h1, RESP_OKAY);
		wait_state(ACODE_ON_AUTO);
		wait_state(ACODE_ENDED);
		repeat (2) @(posedge aclk);
		check(32'(motor_phase_order), 32'h1);
		check(32'(speed_ctrl_valid), 32'h1);
		rd(OFF_STATUS, 32'h10000, 32'h10000, RESP_OKAY);
		wr(OFF_ORDER, 32'h0, RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(32'(speed_ctrl_valid), 32'h0);
		enc_neg <= 1'b0;
		locked <= 1'b1;
		wr(OFF_CTRL, ctrl(1'b1, METH_AUTO, 1'b0, 1'b0, 2'h0), RESP_OKAY);
		wr(OFF_CMD, 32'h1, RESP_OKAY);
		wait_state(ACODE_ON_AUTO);
		wait_state(ACODE_ERROR);
		check(32'(align_error), 32'(ERR_SHAFT_LOCKED));
		locked <= 1'b0;
		$display("automatic test done");
		for (p = 0; p < 2; p++) begin
			wr(OFF_ORDER, 32'(p), RESP_OKAY);
			// invert set on purpose: the stepping must not care
			wr(OFF_CTRL, ctrl(1'b1, METH_DIRTEST, 1'b0, 1'b1, 2'h0), RESP_OKAY);
			wr(OFF_CMD, 32'h1, RESP_OKAY);
			wait_state(ACODE_ON_MANUAL);
			prev = 3'h0;
			for (k = 0; k < 4; k++) begin
				next_drive(prev);
				prev = phase_drive;
				check(32'(prev), exp_drive(k % 3, p[0]));
			end
			if (p == 0) wr(OFF_CMD, 32'h4, RESP_OKAY);
			else wr(OFF_CTRL, ctrl(1'b0, METH_DIRTEST, 1'b0, 1'b1, 2'h0), RESP_OKAY);
			for (n = 0; n < 50 && phase_drive !== 3'h0; n++) @(posedge aclk);
			bounded(phase_drive === 3'h0);
			// torque_removal_command leaves the block enabled, so only a dropped enable reads off
			wait_state(rpa_acode_type'(p ? ACODE_OFF : ACODE_ON_MANUAL));
		end
		$display("direction test done");
		print_verdict();
	end
endmodule
